// [logic/imt_defs.vh]
// Constants of the interrupt mask and temperature offset register bank.
// Assumes inclusion by the bank's single design file only.
`ifndef IMT_DEFS_VH
`define IMT_DEFS_VH

// Register offsets
`define IMT_ADDR_MASK_PRIMARY   8'h1D
`define IMT_ADDR_MASK_SUPPLY    8'h1E
`define IMT_ADDR_INT_OFFSET     8'h1F
`define IMT_ADDR_EXT_OFFSET     8'h20
`define IMT_ADDR_ANALOG_OFFSET  8'h21
`define IMT_ADDR_STAT_PRIMARY   8'h40
`define IMT_ADDR_STAT_SUPPLY    8'h41

// Field positions
`define IMT_BIT_INT_HIGH        0
`define IMT_BIT_INT_LOW         1
`define IMT_BIT_EXT_HIGH        2
`define IMT_BIT_EXT_LOW         3
`define IMT_BIT_EXT_FAULT       4
`define IMT_BIT_AIN_TWO         5
`define IMT_BIT_AIN_THREE       6
`define IMT_BIT_AIN_FOUR        7
`define IMT_BIT_SUPPLY          4

// Reset values
`define IMT_RST_MASK_PRIMARY    8'h00
`define IMT_RST_MASK_SUPPLY     8'h00
`define IMT_RST_INT_OFFSET      8'h00
`define IMT_RST_EXT_OFFSET      8'h00
`define IMT_RST_ANALOG_OFFSET   8'hD8
`define IMT_RST_STATUS          8'h00
`define IMT_RST_RESULT          8'h00
`define IMT_RST_DAC_CODE        8'h00

// Value codes
`define IMT_DAC_DEADBAND        8'hFF
`define IMT_READ_IDLE           8'h00
`define IMT_TEMP_MAX            8'h7F
`define IMT_TEMP_MIN            8'h80

`endif

// [logic/imt_bank.v]
// Interrupt mask, interrupt status and temperature offset register bank.
// Assumes one 100 MHz clock; events and raw results come from same-clock logic.
//
// The strobed register port was decided locally.
`timescale 1ns/10ps
`include "imt_defs.vh"

module imt_bank (
  input  wire       clock_i,         // 100 MHz clock
  input  wire       reset_i,         // Synchronous reset, active high
  input  wire [7:0] addr_i,          // Register address
  input  wire [7:0] wdata_i,         // Write data
  input  wire       wr_i,            // Write strobe
  input  wire       rd_i,            // Read strobe
  output reg  [7:0] rdata_o,         // Read data, cycle after rd_i
  input  wire [7:0] src_evt_i,       // Primary source event pulses
  input  wire       supply_evt_i,    // Any supply limit event pulse
  input  wire       int_valid_i,     // Internal raw result strobe
  input  wire [7:0] int_raw_i,       // Internal raw result, signed
  input  wire       ext_valid_i,     // External raw result strobe
  input  wire [7:0] ext_raw_i,       // External raw result, signed
  output reg        int_valid_o,     // Corrected internal result strobe
  output reg  [7:0] int_temp_o,      // Corrected internal result
  output reg        ext_valid_o,     // Corrected external result strobe
  output reg  [7:0] ext_temp_o,      // Corrected external result
  output reg  [7:0] dac_a_code_o,    // Thermal voltage code for first DAC
  output wire       irq_o            // Interrupt output, active high
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  reg  [7:0] irq_mask_primary;
  reg  [7:0] irq_mask_supply;
  reg  [7:0] internal_temp_offset;
  reg  [7:0] external_temp_offset;
  reg  [7:0] internal_analog_out_offset;
  reg  [7:0] irq_stat_primary;
  reg        irq_stat_supply;

  wire wr_mask_p  = wr_i && (addr_i == `IMT_ADDR_MASK_PRIMARY);
  wire wr_mask_s  = wr_i && (addr_i == `IMT_ADDR_MASK_SUPPLY);
  wire wr_int_off = wr_i && (addr_i == `IMT_ADDR_INT_OFFSET);
  wire wr_ext_off = wr_i && (addr_i == `IMT_ADDR_EXT_OFFSET);
  wire wr_ana_off = wr_i && (addr_i == `IMT_ADDR_ANALOG_OFFSET);
  wire wr_stat_p  = wr_i && (addr_i == `IMT_ADDR_STAT_PRIMARY);
  wire wr_stat_s  = wr_i && (addr_i == `IMT_ADDR_STAT_SUPPLY);

  // Primary mask: one bit per source, a set bit holds that source off the pin
  always @(posedge clock_i) begin
    if (reset_i) begin
      irq_mask_primary <= `IMT_RST_MASK_PRIMARY;
    end else if (wr_mask_p) begin
      irq_mask_primary <= wdata_i;
    end
  end

  // Reserved supply mask bits are stored as written; software keeps them zero
  always @(posedge clock_i) begin
    if (reset_i) begin
      irq_mask_supply <= `IMT_RST_MASK_SUPPLY;
    end else if (wr_mask_s) begin
      irq_mask_supply <= wdata_i;
    end
  end

  // Channel offsets load as zero so an uncalibrated part reports raw values
  always @(posedge clock_i) begin
    if (reset_i) begin
      internal_temp_offset <= `IMT_RST_INT_OFFSET;
    end else if (wr_int_off) begin
      internal_temp_offset <= wdata_i;
    end
  end

  always @(posedge clock_i) begin
    if (reset_i) begin
      external_temp_offset <= `IMT_RST_EXT_OFFSET;
    end else if (wr_ext_off) begin
      external_temp_offset <= wdata_i;
    end
  end

  // Analog offset loads minus 40, which puts 0 V at minus 88 degrees
  always @(posedge clock_i) begin
    if (reset_i) begin
      internal_analog_out_offset <= `IMT_RST_ANALOG_OFFSET;
    end else if (wr_ana_off) begin
      internal_analog_out_offset <= wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status, write one to clear; a new event beats the clear

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_stat
      always @(posedge clock_i) begin
        if (reset_i) begin
          irq_stat_primary[gi] <= 1'b0;
        end else if (src_evt_i[gi]) begin
          irq_stat_primary[gi] <= 1'b1;
        end else if (wr_stat_p && wdata_i[gi]) begin
          irq_stat_primary[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge clock_i) begin
    if (reset_i) begin
      irq_stat_supply <= 1'b0;
    end else if (supply_evt_i) begin
      irq_stat_supply <= 1'b1;
    end else if (wr_stat_s && wdata_i[`IMT_BIT_SUPPLY]) begin
      irq_stat_supply <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt output: each primary bit has its own mask bit

  // Status still sets while its source is masked, so unmasking later raises the pin
  wire       pend_int_high     = irq_stat_primary[`IMT_BIT_INT_HIGH] & ~irq_mask_primary[`IMT_BIT_INT_HIGH];
  wire       pend_int_low      = irq_stat_primary[`IMT_BIT_INT_LOW] & ~irq_mask_primary[`IMT_BIT_INT_LOW];
  wire       pend_ext_high     = irq_stat_primary[`IMT_BIT_EXT_HIGH] & ~irq_mask_primary[`IMT_BIT_EXT_HIGH];
  wire       pend_ext_low      = irq_stat_primary[`IMT_BIT_EXT_LOW] & ~irq_mask_primary[`IMT_BIT_EXT_LOW];
  wire       pend_ext_fault    = irq_stat_primary[`IMT_BIT_EXT_FAULT] & ~irq_mask_primary[`IMT_BIT_EXT_FAULT];
  wire       pend_analog_two   = irq_stat_primary[`IMT_BIT_AIN_TWO] & ~irq_mask_primary[`IMT_BIT_AIN_TWO];
  wire       pend_analog_three = irq_stat_primary[`IMT_BIT_AIN_THREE] & ~irq_mask_primary[`IMT_BIT_AIN_THREE];
  wire       pend_analog_four  = irq_stat_primary[`IMT_BIT_AIN_FOUR] & ~irq_mask_primary[`IMT_BIT_AIN_FOUR];
  wire       pend_supply       = irq_stat_supply & ~irq_mask_supply[`IMT_BIT_SUPPLY];

  wire [7:0] pend_primary      = {pend_analog_four, pend_analog_three, pend_analog_two, pend_ext_fault,
                                  pend_ext_low, pend_ext_high, pend_int_low, pend_int_high};

  assign irq_o = (|pend_primary) | pend_supply;

  ////////////////////////////////////////////////////////////////////////////
  // Offset correction; channel sums saturate so a hot part never reads as cold

  function [7:0] sat_add;
    input [7:0] a;
    input [7:0] b;
    reg   [8:0] s;
    begin
      s = {a[7], a} + {b[7], b};
      if (s[8] != s[7]) begin
        sat_add = s[8] ? `IMT_TEMP_MIN : `IMT_TEMP_MAX;
      end else begin
        sat_add = s[7:0];
      end
    end
  endfunction

  wire [7:0] int_corr = sat_add(int_raw_i, internal_temp_offset);
  wire [7:0] ext_corr = sat_add(ext_raw_i, external_temp_offset);
  wire [8:0] ana_sum  = {int_corr[7], int_corr} +
                        {internal_analog_out_offset[7], internal_analog_out_offset};
  wire       ana_clamp = (ana_sum[8] != ana_sum[7]);

  // Internal channel: corrected result and its one-cycle strobe
  always @(posedge clock_i) begin
    if (reset_i) begin
      int_valid_o <= 1'b0;
      int_temp_o  <= `IMT_RST_RESULT;
    end else begin
      int_valid_o <= int_valid_i;
      if (int_valid_i) begin
        int_temp_o <= int_corr;
      end
    end
  end

  // External channel: same timing as the internal one
  always @(posedge clock_i) begin
    if (reset_i) begin
      ext_valid_o <= 1'b0;
      ext_temp_o  <= `IMT_RST_RESULT;
    end else begin
      ext_valid_o <= ext_valid_i;
      if (ext_valid_i) begin
        ext_temp_o <= ext_corr;
      end
    end
  end

  // First DAC code follows each internal result; overflow either way clamps high
  always @(posedge clock_i) begin
    if (reset_i) begin
      dac_a_code_o <= `IMT_RST_DAC_CODE;
    end else if (int_valid_i) begin
      if (ana_clamp) begin
        dac_a_code_o <= `IMT_DAC_DEADBAND;
      end else begin
        // Offset binary: minus 128 gives 0 V
        dac_a_code_o <= {~ana_sum[7], ana_sum[6:0]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data only in the cycle after the strobe, zero otherwise

  reg [7:0] next_rdata;

  always @* begin
    next_rdata = `IMT_READ_IDLE;
    if (!rd_i) begin
      next_rdata = `IMT_READ_IDLE;
    end else if (addr_i == `IMT_ADDR_MASK_PRIMARY) begin
      next_rdata = irq_mask_primary;
    end else if (addr_i == `IMT_ADDR_MASK_SUPPLY) begin
      next_rdata = irq_mask_supply;
    end else if (addr_i == `IMT_ADDR_INT_OFFSET) begin
      next_rdata = internal_temp_offset;
    end else if (addr_i == `IMT_ADDR_EXT_OFFSET) begin
      next_rdata = external_temp_offset;
    end else if (addr_i == `IMT_ADDR_ANALOG_OFFSET) begin
      next_rdata = internal_analog_out_offset;
    end else if (addr_i == `IMT_ADDR_STAT_PRIMARY) begin
      next_rdata = irq_stat_primary;
    end else if (addr_i == `IMT_ADDR_STAT_SUPPLY) begin
      next_rdata = {3'h0, irq_stat_supply, 4'h0};
    end
  end

  always @(posedge clock_i) begin
    if (reset_i) begin
      rdata_o <= `IMT_READ_IDLE;
    end else begin
      rdata_o <= next_rdata;
    end
  end

endmodule // imt_bank

// [verification/imt_bank_asserts.sv]
// Port checker of the interrupt mask and offset bank.
// Assumes a bind into imt_bank; mask state is mirrored from bus writes.
`timescale 1ns/10ps
module imt_bank_chk (
  input wire       clock_i,      // Clock
  input wire       reset_i,      // Reset
  input wire [7:0] addr_i,       // Address
  input wire [7:0] wdata_i,      // Write data
  input wire       wr_i,         // Write strobe
  input wire       rd_i,         // Read strobe
  input wire [7:0] rdata_o,      // Read data
  input wire [7:0] src_evt_i,    // Events
  input wire       supply_evt_i, // Supply event
  input wire       int_valid_i,  // Strobe in
  input wire       int_valid_o,  // Strobe out
  input wire [7:0] int_temp_o,   // Result
  input wire [7:0] dac_a_code_o, // DAC code
  input wire       irq_o         // Interrupt
);
  reg [7:0] mask1;
  reg       mask2;
  always @(posedge clock_i) begin
    if (reset_i) {mask1, mask2} <= 9'h000;
    else if (wr_i && addr_i == 8'h1D) mask1 <= wdata_i;
    else if (wr_i && addr_i == 8'h1E) mask2 <= wdata_i[4];
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // A write in the same cycle may move the mask, so it is left out
  sequence open_evt_s; !wr_i && (src_evt_i & ~mask1) != 8'h00; endsequence
  sequence all_shut_s; !wr_i && mask1 == 8'hFF && mask2 && !irq_o; endsequence
  irq_primary_a: assert property (open_evt_s |=> irq_o)
    else $error("irq missed primary event");
  irq_supply_a: assert property (!wr_i && supply_evt_i && !mask2 |=> irq_o)
    else $error("irq missed supply event");
  irq_masked_a: assert property (all_shut_s |=> !irq_o)
    else $error("irq from masked source");
  irq_cause_a: assert property ($rose(irq_o) |-> $past(src_evt_i) != 8'h00 || $past(supply_evt_i) || $past(wr_i))
    else $error("irq without cause");
  result_valid_a: assert property (int_valid_i |=> int_valid_o)
    else $error("result strobe lost");
  result_hold_a: assert property (!int_valid_i |=> $stable(int_temp_o) && $stable(dac_a_code_o))
    else $error("result moved without strobe");
  reset_quiet_a: assert property ($fell(reset_i) |-> !irq_o && rdata_o == 8'h00 && dac_a_code_o == 8'h00)
    else $error("outputs not cleared by reset");
  read_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside its cycle");
endmodule // imt_bank_chk

// [verification/imt_bank_tb_top.sv]
// Self-checking bench of the interrupt mask and offset bank.
// Assumes the design and the checker are compiled before this file.
`timescale 1ns/10ps
module imt_bank_tb_top;
  reg        clock_i, reset_i, wr_i, rd_i, supply_evt_i, int_valid_i, ext_valid_i;
  reg  [7:0] addr_i, wdata_i, src_evt_i, int_raw_i, ext_raw_i, seed, io, ao, r;
  wire [7:0] rdata_o, int_temp_o, ext_temp_o, dac_a_code_o;
  wire       irq_o, int_valid_o, ext_valid_o;
  wire [7:0] irq8 = {7'h00, irq_o};
  integer    n_errors, tests_run, cyc, n;
  imt_bank i_dut (.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .src_evt_i(src_evt_i), .supply_evt_i(supply_evt_i),
    .int_valid_i(int_valid_i), .int_raw_i(int_raw_i), .ext_valid_i(ext_valid_i), .ext_raw_i(ext_raw_i),
    .int_valid_o(int_valid_o), .int_temp_o(int_temp_o), .ext_valid_o(ext_valid_o), .ext_temp_o(ext_temp_o),
    .dac_a_code_o(dac_a_code_o), .irq_o(irq_o));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  function [7:0] lfsr(input [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Channel sums saturate; the DAC sum goes to the deadband code instead
  function [8:0] add9(input [7:0] a, input [7:0] b);
    add9 = {a[7], a} + {b[7], b};
  endfunction
  function [7:0] sat(input [8:0] s);
    sat = (s[8] != s[7]) ? (s[8] ? 8'h80 : 8'h7F) : s[7:0];
  endfunction
  function [7:0] dac(input [8:0] s);
    dac = (s[8] != s[7]) ? 8'hFF : s[7:0] ^ 8'h80;
  endfunction
  task chk(input [7:0] got, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clock_i);
      {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
      @(posedge clock_i);
      wr_i <= 1'b0;
      #1;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(posedge clock_i);
      {rd_i, addr_i} <= {1'b1, a};
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1 chk(rdata_o, e);
    end
  endtask
  task drv(input [7:0] s, input p, input v, input [7:0] ri);
    begin
      @(posedge clock_i);
      {src_evt_i, supply_evt_i, int_valid_i, ext_valid_i, int_raw_i, ext_raw_i} <= {s, p, v, v, ri, ~ri};
      @(posedge clock_i);
      {src_evt_i, supply_evt_i, int_valid_i, ext_valid_i} <= 11'h000;
      #1;
    end
  endtask
  task results;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
        $display("TEST PASSED");
      end else begin
        $display("TEST FAILED");
      end
      $finish;
    end
  endtask
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors = n_errors + 1;
      $display("MISMATCH %0t timeout", $time);
      results;
    end
  end
  initial begin
    {reset_i, wr_i, rd_i, supply_evt_i, int_valid_i, ext_valid_i} = 6'h20;
    {addr_i, wdata_i, src_evt_i, int_raw_i, ext_raw_i} = 40'h0;
    {seed, n_errors, tests_run, cyc} = {8'h2B, 32'h0, 32'h0, 32'h0};
    repeat (3) @(posedge clock_i);
    reset_i <= 1'b0;
    for (n = 0; n < 6; n = n + 1) rd(8'h1D + n[7:0], (n == 4) ? 8'hD8 : 8'h00);
    $display("reset values done");
    for (n = 0; n < 8; n = n + 1) begin
      seed = lfsr(seed);
      r = 8'h01 << n;
      wr(8'h1D, seed | r);
      drv(r, 1'b0, 1'b0, 8'h00);
      chk(irq8, 8'h00);
      rd(8'h40, r);
      wr(8'h1D, seed & ~r);
      chk(irq8, 8'h01);
      rd(8'h1D, seed & ~r);
      wr(8'h40, r);
      chk(irq8, 8'h00);
      drv(r, 1'b0, 1'b0, 8'h00);
      chk(irq8, 8'h01);
      wr(8'h40, r);
    end
    wr(8'h1D, 8'hFF);
    wr(8'h1E, 8'h10);
    drv(8'hFF, 1'b1, 1'b0, 8'h00);
    chk(irq8, 8'h00);
    rd(8'h40, 8'hFF);
    rd(8'h41, 8'h10);
    wr(8'h1E, 8'h00);
    chk(irq8, 8'h01);
    wr(8'h41, 8'h10);
    chk(irq8, 8'h00);
    wr(8'h40, 8'hFF);
    wr(8'h1D, 8'h00);
    chk(irq8, 8'h00);
    drv(8'h01, 1'b1, 1'b0, 8'h00);
    chk(irq8, 8'h01);
    wr(8'h40, 8'hFF);
    wr(8'h41, 8'h10);
    chk(irq8, 8'h00);
    @(posedge clock_i);
    {wr_i, addr_i, wdata_i, src_evt_i} <= {1'b1, 8'h40, 8'h01, 8'h01};
    @(posedge clock_i);
    {wr_i, src_evt_i} <= 9'h000;
    #1 chk(irq8, 8'h01);
    rd(8'h40, 8'h01);
    wr(8'h40, 8'h01);
    chk(irq8, 8'h00);
    $display("interrupt masks done");
    for (n = 0; n < 24; n = n + 1) begin
      seed = lfsr(seed);
      io = seed;
      seed = lfsr(seed);
      ao = (n == 1) ? 8'h80 : seed;
      r = lfsr(seed);
      if (n < 2) {io, r} = (n == 0) ? 16'h7F7F : 16'h8080;
      wr(8'h1F, io);
      wr(8'h20, ~io);
      wr(8'h21, ao);
      drv(8'h00, 1'b0, 1'b1, r);
      chk({6'h00, int_valid_o, ext_valid_o}, 8'h03);
      chk(int_temp_o, sat(add9(r, io)));
      chk(ext_temp_o, sat(add9(~r, ~io)));
      chk(dac_a_code_o, dac(add9(sat(add9(r, io)), ao)));
      rd(8'h1F, io);
    end
    $display("offsets done");
    drv(8'hFF, 1'b1, 1'b0, 8'h00);
    chk(irq8, 8'h01);
    @(posedge clock_i);
    reset_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    reset_i <= 1'b0;
    #1 chk(irq8, 8'h00);
    chk(dac_a_code_o, 8'h00);
    for (n = 0; n < 6; n = n + 1) rd(8'h1D + n[7:0], (n == 4) ? 8'hD8 : 8'h00);
    rd(8'h40, 8'h00);
    rd(8'h41, 8'h00);
    $display("second reset done");
    results;
  end
endmodule // imt_bank_tb_top
bind imt_bank imt_bank_chk i_chk (.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .src_evt_i(src_evt_i), .supply_evt_i(supply_evt_i),
  .int_valid_i(int_valid_i), .int_valid_o(int_valid_o), .int_temp_o(int_temp_o),
  .dac_a_code_o(dac_a_code_o), .irq_o(irq_o));
